/* adc_pkg.sv */
// Shared constants, state type and gray-to-binary helper for the converter interface
package adc_pkg;

	// System clock period
	localparam int CLK_NS        = 10;

	// Conversion time window and the target inside it
	localparam int T_CONV_MIN_NS = 270;
	localparam int T_CONV_MAX_NS = 320;
	localparam int T_CONV_NS     = 290;
	localparam int CONV_MIN_CYC  = (T_CONV_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONV_MAX_CYC  = T_CONV_MAX_NS / CLK_NS;
	localparam int CONV_CYC      = (T_CONV_NS + CLK_NS - 1) / CLK_NS;

	// Pin synchroniser plus edge detect latency, taken off the count
	localparam int SYNC_LAT      = 3;
	localparam int CONV_W        = 5;
	localparam logic [CONV_W-1:0] CONV_LOAD_C =
		CONV_W'(CONV_CYC - SYNC_LAT);

	// Serial word layout
	localparam int RESULT_BITS   = 16;
	localparam int STATUS_BITS   = 6;
	localparam int WORD_BITS     = RESULT_BITS + STATUS_BITS;
	localparam int CNT_W         = 6;
	localparam logic [CNT_W-1:0] NBITS_PLAIN_C  = 6'h10;
	localparam logic [CNT_W-1:0] NBITS_STATUS_C = 6'h16;
	localparam logic [CNT_W-1:0] WRITE_BITS_C   = 6'h10;
	localparam logic [STATUS_BITS-1:0] NO_STATUS_C = 6'h00;

	// Converter sequencing states, gray along idle-convert-read
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CONV = 2'h1,
		ST_READ = 2'h3
	} conv_state_t;

	// Gray to binary for edge counters crossing from the link clock
	function automatic logic [CNT_W-1:0] gray2bin(
		input logic [CNT_W-1:0] g
	);
		logic [CNT_W-1:0] b;
		b[CNT_W-1] = g[CNT_W-1];
		for (int i = CNT_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : gray2bin

endpackage : adc_pkg

/* sync2.sv */
// Two flip-flop synchroniser for levels and gray codes
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	// Asynchronous input and synchronised output
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= d_i;
			q_reg    <= meta_reg;
		end
	end

	assign q_o = q_reg;

endmodule : sync2

/* link_edge_counter.sv */
// Gray-coded edge counter running on the serial link clock
`timescale 1ns/1ps
module link_edge_counter #(
	parameter int W = 6
) (
	// Link edge to count and reset
	input  wire logic         edge_clk_i,
	input  wire logic         rst_i,
	// Gray count, one bit changes per edge
	output logic      [W-1:0] gray_o
);

	logic [W-1:0] bin_reg;
	logic [W-1:0] bin_next;
	logic [W-1:0] gray_reg;
	logic [W-1:0] gray_next;

	// Next count and its gray form
	always_comb begin
		bin_next  = bin_reg + 1'b1;
		gray_next = bin_next ^ (bin_next >> 1);
	end

	// Asynchronous reset: the link clock may be stopped during reset
	always_ff @(posedge edge_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bin_reg  <= '0;
			gray_reg <= '0;
		end else begin
			bin_reg  <= bin_next;
			gray_reg <= gray_next;
		end
	end

	assign gray_o = gray_reg;

endmodule : link_edge_counter

/* adc_serial_core.sv */
// Converter sequencing and serial readout behind the interface pins
//
// Functional notes
// - Result becomes available 270 to 320 ns after the strobe rises.
// - Chip-select mode: strobe or data-in low drives output, msb first.
// - Output bit advances after every serial clock falling edge.
// - Chip-select output released on strobe and data-in both high, or after last bit.
// - Daisy-chain: data-in captured on serial clock rising edge.
// - Full rate only with turbo, which lets readout overlap conversion.
// - Strobe rise starts conversion and latches chip-select or chain mode.
`timescale 1ns/1ps
module adc_serial_core (
	// System clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         sys_rst_i,
	// Serial link pins
	input  wire logic                         link_sck_i,
	input  wire logic                         convert_strobe_i,
	input  wire logic                         serial_data_in_i,
	output logic                              serial_data_out_o,
	output logic                              serial_data_out_oe_o,
	// Sampled value and status from the converter core
	input  wire logic [adc_pkg::RESULT_BITS-1:0] sample_i,
	input  wire logic [adc_pkg::STATUS_BITS-1:0] status_i,
	// Configuration
	input  wire logic                         turbo_en_i,
	input  wire logic                         status_en_i,
	// Status and received write data
	output logic                              busy_o,
	output logic                              result_valid_o,
	output logic                              cs_mode_o,
	output logic [adc_pkg::RESULT_BITS-1:0]   write_word_o,
	output logic                              write_valid_o
);

	localparam int CW = adc_pkg::CNT_W;
	localparam int WB = adc_pkg::WORD_BITS;
	localparam int RB = adc_pkg::RESULT_BITS;
	localparam int A_CONV_DONE = int'(adc_pkg::CONV_LOAD_C) + 2;

	// Synchronised pins and edge counts
	logic [1:0]    pins_s;
	logic          strobe_s;
	logic          sdi_s;
	logic [CW-1:0] fall_gray;
	logic [CW-1:0] rise_gray;
	logic [CW-1:0] fall_gray_s;
	logic [CW-1:0] rise_gray_s;
	logic [CW-1:0] fall_bin_w;
	logic [CW-1:0] rise_bin_w;

	// Sequencer state
	adc_pkg::conv_state_t         state_reg,  state_next;
	logic [adc_pkg::CONV_W-1:0]   cnt_reg,    cnt_next;
	logic                         cs_reg,     cs_next;
	logic [RB-1:0]                sample_reg, sample_next;
	logic [WB-1:0]                word_reg,   word_next;
	logic [CW-1:0]                nbits_reg,  nbits_next;
	logic                         live_reg,   live_next;
	logic [CW-1:0]                fbase_reg,  fbase_next;
	logic [CW-1:0]                rbase_reg,  rbase_next;
	logic                         strobe_d_reg;
	logic                         busy_reg,   busy_next;
	logic                         done_reg,   done_next;
	logic [RB-1:0]                wword_reg,  wword_next;
	logic                         wvalid_reg, wvalid_next;
	logic                         sdo_reg,    sdo_next;
	logic                         oe_reg,     oe_next;

	// Link domain receive shifter
	logic [RB-1:0] rx_reg, rx_next;

	// Helpers
	logic          start_w;
	logic          end_w;
	logic [CW-1:0] idx_w;
	logic [WB-1:0] sh_w;
	logic          left_w;
	logic          sel_w;
	logic          msb_w;

	// Pins from the host cross into the system clock first
	sync2 #(
		.W (2)
	) u_pin_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.d_i       ({convert_strobe_i, serial_data_in_i}),
		.q_o       (pins_s)
	);

	assign strobe_s = pins_s[1];
	assign sdi_s    = pins_s[0];

	// Falling edges pace the output bits
	link_edge_counter #(
		.W (CW)
	) u_fall_cnt (
		.edge_clk_i (~link_sck_i),
		.rst_i      (sys_rst_i),
		.gray_o     (fall_gray)
	);

	// Rising edges count received bits
	link_edge_counter #(
		.W (CW)
	) u_rise_cnt (
		.edge_clk_i (link_sck_i),
		.rst_i      (sys_rst_i),
		.gray_o     (rise_gray)
	);

	// Gray counts cross as words, one bit changing per edge
	sync2 #(
		.W (2 * CW)
	) u_cnt_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.d_i       ({fall_gray, rise_gray}),
		.q_o       ({fall_gray_s, rise_gray_s})
	);

	// Receive shift, next value
	always_comb begin
		rx_next = {rx_reg[RB-2:0], serial_data_in_i};
	end

	// Data-in taken on each serial clock rise
	always_ff @(posedge link_sck_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_reg <= '0;
		end else begin
			rx_reg <= rx_next;
		end
	end

	// Edge decode and output bit selection
	always_comb begin
		fall_bin_w = adc_pkg::gray2bin(fall_gray_s);
		rise_bin_w = adc_pkg::gray2bin(rise_gray_s);
		start_w    = strobe_s & ~strobe_d_reg;
		end_w      = ~strobe_s & strobe_d_reg;
		idx_w      = fall_bin_w - fbase_reg;
		sh_w       = word_reg << idx_w;
		left_w     = live_reg && (idx_w < nbits_reg);
		sel_w      = !(strobe_s && sdi_s);
		msb_w      = word_reg[WB-1];
	end

	// Sequencer next values
	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		cs_next     = cs_reg;
		sample_next = sample_reg;
		word_next   = word_reg;
		nbits_next  = nbits_reg;
		live_next   = live_reg;
		fbase_next  = fbase_reg;
		rbase_next  = rbase_reg;
		wword_next  = wword_reg;
		wvalid_next = 1'b0;
		done_next   = 1'b0;
		case (state_reg)
			adc_pkg::ST_IDLE: begin
				state_next = adc_pkg::ST_IDLE;
			end
			adc_pkg::ST_CONV: begin
				if (cnt_reg == '0) begin
					state_next = adc_pkg::ST_READ;
					done_next  = 1'b1;
					live_next  = 1'b1;
					fbase_next = fall_bin_w;
					if (status_en_i) begin
						word_next  = {sample_reg, status_i};
						nbits_next = adc_pkg::NBITS_STATUS_C;
					end else begin
						word_next  = {sample_reg, adc_pkg::NO_STATUS_C};
						nbits_next = adc_pkg::NBITS_PLAIN_C;
					end
				end else begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			adc_pkg::ST_READ: begin
				state_next = adc_pkg::ST_READ;
			end
			default: begin
				state_next = adc_pkg::ST_IDLE;
			end
		endcase
		// Frame start marks where write bits begin
		if (end_w) begin
			rbase_next = rise_bin_w;
		end
		// New strobe rise restarts the conversion from any state; readout stops only without turbo
		if (start_w) begin
			state_next  = adc_pkg::ST_CONV;
			cnt_next    = adc_pkg::CONV_LOAD_C;
			cs_next     = sdi_s;
			sample_next = sample_i;
			// Without turbo the old word is dropped at conversion start
			if (!turbo_en_i) begin
				live_next = 1'b0;
			end
			// Quiet time before strobe rise keeps the shifter static
			if ((rise_bin_w - rbase_reg) >= adc_pkg::WRITE_BITS_C) begin
				wword_next  = rx_reg;
				wvalid_next = 1'b1;
			end
		end
		busy_next = (state_next == adc_pkg::ST_CONV);
	end

	// Output pin next values
	always_comb begin
		if (cs_reg) begin
			oe_next = sel_w && left_w;
		end else begin
			oe_next = live_reg;
		end
		sdo_next = left_w ? sh_w[WB-1] : 1'b0;
	end

	// Register all system domain state
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg    <= adc_pkg::ST_IDLE;
			cnt_reg      <= '0;
			cs_reg       <= 1'b1;
			sample_reg   <= '0;
			word_reg     <= '0;
			nbits_reg    <= '0;
			live_reg     <= 1'b0;
			fbase_reg    <= '0;
			rbase_reg    <= '0;
			strobe_d_reg <= 1'b0;
			busy_reg     <= 1'b0;
			done_reg     <= 1'b0;
			wword_reg    <= '0;
			wvalid_reg   <= 1'b0;
			sdo_reg      <= 1'b0;
			oe_reg       <= 1'b0;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			cs_reg       <= cs_next;
			sample_reg   <= sample_next;
			word_reg     <= word_next;
			nbits_reg    <= nbits_next;
			live_reg     <= live_next;
			fbase_reg    <= fbase_next;
			rbase_reg    <= rbase_next;
			strobe_d_reg <= strobe_s;
			busy_reg     <= busy_next;
			done_reg     <= done_next;
			wword_reg    <= wword_next;
			wvalid_reg   <= wvalid_next;
			sdo_reg      <= sdo_next;
			oe_reg       <= oe_next;
		end
	end

	// Outputs straight from flip-flops
	assign serial_data_out_o    = sdo_reg;
	assign serial_data_out_oe_o = oe_reg;
	assign busy_o               = busy_reg;
	assign result_valid_o       = done_reg;
	assign cs_mode_o            = cs_reg;
	assign write_word_o         = wword_reg;
	assign write_valid_o        = wvalid_reg;

	// Checks on the system clock, except the data-in capture check on the serial clock rise
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_start;
		start_w;
	endsequence

	sequence s_first_bit;
		left_w && (idx_w == '0);
	endsequence

	a_conv_done_time: assert property (
		s_start |-> ##A_CONV_DONE result_valid_o
	) else $error("result not ready at the conversion time");

	a_busy_during: assert property (
		s_start |=> busy_o [*8]
	) else $error("busy dropped early in conversion");

	a_mode_latch: assert property (
		s_start |=> (cs_mode_o == $past(sdi_s))
	) else $error("interface mode not latched at strobe rise");

	a_msb_first: assert property (
		s_first_bit |=> (serial_data_out_o == $past(msb_w))
	) else $error("first output bit is not the msb");

	a_bit_hold: assert property (
		(left_w && $stable(fall_bin_w) && $stable(left_w))
			##1 $stable(fall_bin_w) |=> $stable(serial_data_out_o)
	) else $error("output bit moved without a falling edge");

	a_release_sel: assert property (
		(cs_reg && strobe_s && sdi_s) |=> !serial_data_out_oe_o
	) else $error("output not released on deselect");

	a_release_last: assert property (
		(cs_reg && live_reg && !left_w) |=> !serial_data_out_oe_o
	) else $error("output not released after last bit");

	a_turbo_keep: assert property (
		(s_start and (turbo_en_i && live_reg)) |=> live_reg
	) else $error("turbo readout dropped at conversion start");

	a_rx_capture: assert property (
		@(posedge link_sck_i) disable iff (sys_rst_i)
		1'b1 |=> (rx_reg[0] == $past(serial_data_in_i))
	) else $error("data-in not taken on clock rise");

endmodule : adc_serial_core

/* host_model.sv */
// Host controller model driving strobe, serial clock and data-in
`timescale 1ns/1ps
module host_model (
	// Pins toward the converter
	output logic      link_sck_o,
	output logic      convert_strobe_o,
	output logic      serial_data_in_o,
	// Returned data and its enable
	input  wire logic serial_data_out_i,
	input  wire logic serial_data_out_oe_i
);
	realtime t_rise;

	// Clock parked low outside frames, so no edge near the strobe
	initial begin
		link_sck_o       = 1'b0;
		convert_strobe_o = 1'b0;
		serial_data_in_o = 1'b0;
		t_rise           = 0.0;
	end

	// Mode level set up early and held well past the strobe edge
	task automatic start(input logic mode);
		serial_data_in_o = mode;
		#5.3 convert_strobe_o = 1'b1;
		t_rise = $realtime;
		#15;
	endtask : start

	// Strobe low, then n bits at 48 ns, capture just before each fall
	task automatic frame(input int n, input logic [21:0] wd,
		output logic [21:0] rd);
		rd = 22'h000000;
		convert_strobe_o = 1'b0;
		// Caller waits out the conversion first, far past the quiet time
		for (int i = n - 1; i >= 0; i--) begin
			serial_data_in_o = wd[i];
			#24 link_sck_o = 1'b1;
			#24 rd = {rd[20:0],
				serial_data_out_oe_i ? serial_data_out_i : 1'bx};
			link_sck_o = 1'b0;
		end
		// Quiet gap before any new strobe rise; frames stay far below rate
		#70;
	endtask : frame
endmodule : host_model

/* test_sar_adc_serial_conversion_timing.sv */
// Self-checking bench for the converter serial timing block
`timescale 1ns/1ps
module test_sar_adc_serial_conversion_timing;
	logic        clk_i;
	logic        sys_rst_i;
	logic        sck, convert_strobe, serial_data_in, serial_data_out, sdo_oe;
	logic [15:0] sample_i;
	logic [5:0]  status_i;
	logic        turbo_en_i, status_en_i;
	logic        busy_o, result_valid_o, cs_mode_o, write_valid_o;
	logic [15:0] write_word_o;
	logic [21:0] prev_w;
	int          bad_count = 0;
	int          n_tests   = 0;
	int          wv_cnt    = 0;
	int          prev_n    = 0;

	// Pins driven by the host model
	host_model host (.link_sck_o(sck), .convert_strobe_o(convert_strobe),
		.serial_data_in_o(serial_data_in), .serial_data_out_i(serial_data_out),
		.serial_data_out_oe_i(sdo_oe));

	adc_serial_core DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.link_sck_i(sck), .convert_strobe_i(convert_strobe),
		.serial_data_in_i(serial_data_in), .serial_data_out_o(serial_data_out),
		.serial_data_out_oe_o(sdo_oe), .sample_i(sample_i),
		.status_i(status_i), .turbo_en_i(turbo_en_i),
		.status_en_i(status_en_i), .busy_o(busy_o),
		.result_valid_o(result_valid_o), .cs_mode_o(cs_mode_o),
		.write_word_o(write_word_o), .write_valid_o(write_valid_o));

	// System clock, 10 ns
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Write pulses counted as they come, one cycle wide
	always @(posedge clk_i) begin
		if (write_valid_o === 1'b1) wv_cnt++;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic conclude;
		$display("Mismatches %0d of %0d checks", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude

	// One conversion and readout of n bits; judges timing, word and release
	task automatic run_cycle(input logic mode, input logic st, input int n,
		input logic [15:0] smp, input logic [21:0] wd);
		logic [21:0] rd;
		logic [21:0] exp;
		realtime     dt;
		int          wv0;
		int          k;
		int          wl;
		@(negedge clk_i);
		sample_i    = smp;
		status_i    = ~smp[5:0];
		status_en_i = st;
		wv0         = wv_cnt;
		wl          = st ? 22 : 16;
		exp         = st ? {smp, ~smp[5:0]} : {6'h00, smp};
		host.start(mode);
		k = 0;
		while (result_valid_o !== 1'b1 && k < 40) begin
			@(posedge clk_i);
			#1;
			k++;
			if (k == 6 && mode) check(sdo_oe, 1'b0);
			if (k == 15) check(busy_o, 1'b1);
		end
		dt = $realtime - 1.0 - host.t_rise;
		check(dt >= 270.0 && dt <= 320.0, 1'b1);
		check(busy_o, 1'b0);
		check(cs_mode_o, mode);
		check(wv_cnt - wv0, prev_n >= 16);
		if (prev_n >= 16) check(write_word_o, prev_w[15:0]);
		host.frame(n, wd, rd);
		check(rd, exp >> (wl - n));
		check(sdo_oe, n < wl || !mode);
		prev_n = n;
		prev_w = wd;
	endtask : run_cycle

	task automatic cs_plain;
		run_cycle(1'b1, 1'b0, 16, 16'hA5C3, 22'h003C5A);
	endtask : cs_plain

	task automatic cs_status;
		run_cycle(1'b1, 1'b1, 22, 16'h5A3C, 22'h2B1E7D);
	endtask : cs_status

	// Short read, output still enabled at frame end; next strobe comes with data-in low
	task automatic cs_abort;
		run_cycle(1'b1, 1'b0, 8, 16'hFF00, 22'h00000F);
	endtask : cs_abort

	task automatic daisy;
		run_cycle(1'b0, 1'b0, 16, 16'h8001, 22'h001234);
	endtask : daisy

	task automatic turbo_status;
		turbo_en_i = 1'b1;
		run_cycle(1'b1, 1'b1, 22, 16'h7FFE, 22'h15AA55);
		run_cycle(1'b1, 1'b0, 16, 16'h0001, 22'h000000);
	endtask : turbo_status

	// Hang guard, well past the expected few microseconds
	initial begin
		#60000;
		bad_count++;
		conclude();
	end

	// Reset, reset values, then the scenarios
	initial begin
		sys_rst_i   = 1'b1;
		sample_i    = 16'h0000;
		status_i    = 6'h00;
		turbo_en_i  = 1'b0;
		status_en_i = 1'b0;
		repeat (3) @(negedge clk_i);
		sys_rst_i = 1'b0;
		repeat (3) @(negedge clk_i);
		check({cs_mode_o, busy_o, sdo_oe, write_valid_o}, 4'h8);
		cs_plain();
		cs_status();
		cs_abort();
		daisy();
		turbo_status();
		conclude();
	end
endmodule : test_sar_adc_serial_conversion_timing
